// ### pkg/scem_defs.svh
// Constants for the serial configuration error monitor.
`ifndef SCEM_DEFS_SVH
`define SCEM_DEFS_SVH

// Stored bitstream size and bit address width.
`define SCEM_STORE_BITS 256
`define SCEM_ADDR_W 8
`define SCEM_LAST_ADDR 8'hff

// System clock period and the power-up delay.
`define SCEM_CLK_PERIOD_NS 25
`define SCEM_POR_DELAY_MS 100
`define SCEM_POR_CYCLES (((`SCEM_POR_DELAY_MS * 1000000) + `SCEM_CLK_PERIOD_NS - 1) / `SCEM_CLK_PERIOD_NS)
`define SCEM_POR_CNT_W 22

// Least time the shared line is held low on an error.
`define SCEM_RST_MIN_NS 100
`define SCEM_RST_CYCLES ((`SCEM_RST_MIN_NS + `SCEM_CLK_PERIOD_NS - 1) / `SCEM_CLK_PERIOD_NS)
`define SCEM_HOLD_CNT_W 3

`endif

// ### pkg/scem_pkg.sv
// Types shared by the serial configuration error monitor.
`include "scem_defs.svh"

package scem_pkg;

  typedef logic [`SCEM_ADDR_W-1:0] scem_addr_t;

  typedef logic [`SCEM_STORE_BITS-1:0] scem_store_t;

  typedef enum logic [2:0] {
    st_por,
    st_wait,
    st_run,
    st_done,
    st_err
  } scem_state_t;

endpackage

// ### rtl/scem_sync.sv
// Two flip-flop level synchroniser for a group of independent bits.
`timescale 1ns/1ps

module scem_sync #(
  parameter int W = 1
) (
  // Destination clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Only the second stage is visible outside.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // scem_sync

// ### rtl/scem_link.sv
// Serial bit clock domain: address counter and serial data output.
`timescale 1ns/1ps
`include "scem_defs.svh"

module scem_link
  import scem_pkg::*;
(
  // Link clock and reset already synchronised to it.
  input wire logic serial_bit_clock,
  input wire logic link_rst,
  // Raw pin levels.
  input wire logic line_in,
  input wire logic chip_select_n,
  // Stored bitstream, static while the link runs.
  input wire scem_store_t store,
  // Serial data pin.
  output logic serial_data_out,
  output logic serial_data_oe,
  // Level: the last stored bit has been delivered.
  output logic all_sent
);

  localparam scem_addr_t LAST_ADDR = `SCEM_LAST_ADDR;

  logic [1:0] pins_s;
  logic line_s;
  logic cs_s;
  logic count_en;
  logic at_last;
  scem_addr_t addr_q;
  scem_addr_t addr_next;
  logic sent_q;
  logic data_q;
  logic oe_q;

  scem_sync #(.W(2)) u_pin_sync (
    .clk(serial_bit_clock),
    .rst(link_rst),
    .async_in({line_in, chip_select_n}),
    .sync_out(pins_s)
  );

  assign line_s = pins_s[1];
  assign cs_s = pins_s[0];
  // Counting trails the enable by one edge so bit zero is shown before the first advance.
  assign count_en = line_s & ~cs_s & ~sent_q & oe_q;
  assign at_last = (addr_q == LAST_ADDR);
  assign addr_next = scem_addr_t'(addr_q + 8'h01);

  // While the line is low the counter is held at zero with bit zero presented.
  always_ff @(posedge serial_bit_clock)
  begin
    if (link_rst || !line_s)
    begin
      addr_q <= '0;
      sent_q <= 1'b0;
      data_q <= store[0];
    end
    else if (count_en && at_last)
    begin
      sent_q <= 1'b1;
      data_q <= 1'b0;
    end
    else if (count_en)
    begin
      addr_q <= addr_next;
      data_q <= store[addr_next];
    end
  end

  always_ff @(posedge serial_bit_clock)
  begin
    if (link_rst)
    begin
      oe_q <= 1'b0;
    end
    else
    begin
      oe_q <= line_s & ~cs_s & ~(sent_q | (count_en & at_last));
    end
  end

  assign serial_data_out = data_q;
  assign serial_data_oe = oe_q;
  assign all_sent = sent_q;

  property p_count_step;
    @(posedge serial_bit_clock) disable iff (link_rst)
    (count_en && !at_last) |=> (addr_q == scem_addr_t'($past(addr_q) + 8'h01));
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("address did not advance on an enabled link edge");

  property p_line_clear;
    @(posedge serial_bit_clock) disable iff (link_rst)
    !line_s |=> (addr_q == '0) && !sent_q;
  endproperty
  a_line_clear: assert property (p_line_clear)
    else $error("low line did not clear the address counter");

  property p_last_sent;
    @(posedge serial_bit_clock) disable iff (link_rst)
    (count_en && at_last) |=> sent_q ##1 sent_q;
  endproperty
  a_last_sent: assert property (p_last_sent)
    else $error("last bit delivered but sent flag not set");

endmodule // scem_link

// ### rtl/scem_top.sv
// Serial configuration memory: power-up delay, error check and restart control.
`timescale 1ns/1ps
`include "scem_defs.svh"

// Overview of operation
// - After reset the block waits about 100 ms, counted on the system clock, before serving bits.
// - The chip-select pin is sampled as the target's load-complete level during configuration.
// - If load-complete is still low when the last stored bit has gone out, an error is raised.
// - If load-complete rises before the last stored bit has gone out, an error is raised.
// - On an error the block pulls the shared enable/reset line low so the target sees it.
// - With the stored auto-restart option set, a new pass starts by itself after an error.
// - A low level driven on the shared line by the target returns a running or finished pass to the wait state.
// - A stored bit selects 3.3-V or 5.0-V interface mode and can be reprogrammed whenever no pass is running.
// - While chip select is low, each rising serial clock edge advances the bit address and presents the next bit, up to the last bit.
// - A low shared line clears the address counter and a high one enables data and counting.
module scem_top
  import scem_pkg::*;
#(
  parameter int unsigned POR_CYCLES = `SCEM_POR_CYCLES
) (
  // System clock and synchronous reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Link pins facing the target.
  input wire logic serial_bit_clock,
  input wire logic chip_select_n,
  input wire logic line_in,
  output logic line_out,
  output logic line_oe,
  output logic serial_data_out,
  output logic serial_data_oe,
  // Programming port, accepted only while no pass is running.
  input wire logic prog_bit_we,
  input wire scem_addr_t prog_bit_addr,
  input wire logic prog_bit_data,
  input wire logic prog_opt_we,
  input wire logic prog_opt_auto_restart,
  input wire logic prog_opt_low_voltage,
  // Status.
  output logic low_voltage_mode,
  output logic config_error,
  output logic config_done,
  output logic por_busy
);

  localparam logic [`SCEM_POR_CNT_W-1:0] POR_LAST = `SCEM_POR_CNT_W'(POR_CYCLES - 1);
  localparam logic [`SCEM_HOLD_CNT_W-1:0] HOLD_LAST =
    `SCEM_HOLD_CNT_W'(`SCEM_RST_CYCLES - 1);

  // True while bits may be flowing to the target.
  function automatic logic scem_pass_active(input scem_state_t st);
    scem_pass_active = (st == st_run) || (st == st_wait);
  endfunction

  scem_state_t state_q;
  scem_state_t state_d;
  logic [`SCEM_POR_CNT_W-1:0] por_cnt_q;
  logic [`SCEM_HOLD_CNT_W-1:0] hold_cnt_q;
  scem_store_t store_q;
  logic opt_auto_q;
  logic opt_low_q;
  logic [2:0] sys_s;
  logic line_s;
  logic load_s;
  logic sent_s;
  logic sent_prev_q;
  logic sent_rise;
  logic rise_q;
  logic armed_q;
  logic link_all_sent;
  logic link_rst;
  logic link_hold_q;
  logic prog_ok;
  logic por_end;
  logic hold_end;
  logic late_fail;
  logic early_fail;
  logic target_reset;
  logic line_oe_q;
  logic error_q;
  logic done_q;

  // The link stays in reset through system reset and the power-up delay, so no bit leaves early.
  scem_sync #(.W(1)) u_rst_sync (
    .clk(serial_bit_clock),
    .rst(1'b0),
    .async_in(link_hold_q),
    .sync_out(link_rst)
  );

  scem_sync #(.W(3)) u_sys_sync (
    .clk(sys_clk),
    .rst(sys_rst),
    .async_in({line_in, chip_select_n, link_all_sent}),
    .sync_out(sys_s)
  );

  assign line_s = sys_s[2];
  assign load_s = sys_s[1];
  assign sent_s = sys_s[0];

  scem_link u_link (
    .serial_bit_clock(serial_bit_clock),
    .link_rst(link_rst),
    .line_in(line_in),
    .chip_select_n(chip_select_n),
    .store(store_q),
    .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe),
    .all_sent(link_all_sent)
  );

  // The store is read across domains, so it may only change while no pass runs.
  assign prog_ok = !scem_pass_active(state_q);

  always_ff @(posedge sys_clk)
  begin
    if (prog_ok && prog_bit_we)
    begin
      store_q[prog_bit_addr] <= prog_bit_data;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      opt_auto_q <= 1'b0;
      opt_low_q <= 1'b0;
    end
    else if (prog_ok && prog_opt_we)
    begin
      opt_auto_q <= prog_opt_auto_restart;
      opt_low_q <= prog_opt_low_voltage;
    end
  end

  assign sent_rise = sent_s & ~sent_prev_q;
  assign por_end = (por_cnt_q == POR_LAST);
  assign hold_end = (hold_cnt_q == HOLD_LAST);
  assign target_reset = !line_s;
  assign late_fail = rise_q && !load_s;
  assign early_fail = armed_q && load_s && !sent_s;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      st_por:
      begin
        if (por_end)
        begin
          state_d = st_wait;
        end
      end
      st_wait:
      begin
        if (line_s)
        begin
          state_d = st_run;
        end
      end
      st_run:
      begin
        if (target_reset)
        begin
          state_d = st_wait;
        end
        else if (late_fail || early_fail)
        begin
          state_d = st_err;
        end
        else if (rise_q)
        begin
          state_d = st_done;
        end
      end
      st_done:
      begin
        if (target_reset)
        begin
          state_d = st_wait;
        end
      end
      st_err:
      begin
        if (hold_end && opt_auto_q)
        begin
          state_d = st_wait;
        end
      end
      default:
      begin
        state_d = st_por;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_q <= st_por;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      por_cnt_q <= '0;
    end
    else if (state_q == st_por && !por_end)
    begin
      por_cnt_q <= `SCEM_POR_CNT_W'(por_cnt_q + 22'h000001);
    end
  end

  // The hold counter saturates so the line is low for at least the reset minimum.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || state_q != st_err)
    begin
      hold_cnt_q <= '0;
    end
    else if (!hold_end)
    begin
      hold_cnt_q <= `SCEM_HOLD_CNT_W'(hold_cnt_q + 3'h1);
    end
  end

  // A stale sent flag from an earlier pass must drop before the early check arms.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sent_prev_q <= 1'b0;
      rise_q <= 1'b0;
      armed_q <= 1'b0;
    end
    else
    begin
      sent_prev_q <= sent_s;
      // Judged a cycle late, as load-complete may trail the sent flag through its own flops.
      rise_q <= sent_rise;
      armed_q <= (state_q == st_run) && (armed_q || !sent_s);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      line_oe_q <= 1'b0;
      link_hold_q <= 1'b1;
      error_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      line_oe_q <= (state_d == st_err);
      link_hold_q <= (state_d == st_por);
      error_q <= (state_d == st_err) || (error_q && state_d != st_run);
      done_q <= (state_d == st_done);
    end
  end

  assign line_out = 1'b0;
  assign line_oe = line_oe_q;
  assign low_voltage_mode = opt_low_q;
  assign config_error = error_q;
  assign config_done = done_q;
  assign por_busy = (state_q == st_por);

  property p_por_hold;
    @(posedge sys_clk) disable iff (sys_rst)
    (state_q == st_por && por_cnt_q != POR_LAST) |=> (state_q == st_por);
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("power-up delay left early");

  property p_por_full;
    @(posedge sys_clk) disable iff (sys_rst)
    ($past(state_q) == st_por && state_q != st_por) |-> ($past(por_cnt_q) == POR_LAST);
  endproperty
  a_por_full: assert property (p_por_full)
    else $error("power-up delay count incomplete");

  property p_load_sample;
    @(posedge sys_clk) disable iff (sys_rst)
    (!$past(sys_rst) && !$past(sys_rst, 2)) |-> (load_s == $past(chip_select_n, 2));
  endproperty
  a_load_sample: assert property (p_load_sample)
    else $error("load-complete sample does not follow chip select");

  property p_late_error;
    @(posedge sys_clk) disable iff (sys_rst)
    (state_q == st_run && line_s && rise_q && !load_s) |=> (state_q == st_err) ##1 line_oe;
  endproperty
  a_late_error: assert property (p_late_error)
    else $error("missing load-complete after last bit not flagged");

  property p_early_error;
    @(posedge sys_clk) disable iff (sys_rst)
    (state_q == st_run && line_s && armed_q && load_s && !sent_s) |=> (state_q == st_err);
  endproperty
  a_early_error: assert property (p_early_error)
    else $error("early load-complete not flagged");

  property p_err_drive;
    @(posedge sys_clk) disable iff (sys_rst)
    (state_q == st_err) |-> (line_oe && !line_out);
  endproperty
  a_err_drive: assert property (p_err_drive)
    else $error("line not pulled low during error");

  property p_release;
    @(posedge sys_clk) disable iff (sys_rst)
    (state_q != st_err && $past(state_q) != st_err) |-> !line_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("line driven while no error pending");

  property p_auto_restart;
    @(posedge sys_clk) disable iff (sys_rst)
    (state_q == st_err && opt_auto_q && hold_end) |=> (state_q == st_wait) && !line_oe;
  endproperty
  a_auto_restart: assert property (p_auto_restart)
    else $error("auto-restart did not begin a new pass");

  property p_no_restart;
    @(posedge sys_clk) disable iff (sys_rst)
    (state_q == st_err && !opt_auto_q) |=> (state_q == st_err) [*3];
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("error released without auto-restart");

  property p_target_reset;
    @(posedge sys_clk) disable iff (sys_rst)
    ((state_q == st_run || state_q == st_done) && !line_s) |=> (state_q == st_wait);
  endproperty
  a_target_reset: assert property (p_target_reset)
    else $error("target fault did not reset the block");

  property p_mode_fixed;
    @(posedge sys_clk) disable iff (sys_rst)
    scem_pass_active(state_q) |=> $stable(low_voltage_mode);
  endproperty
  a_mode_fixed: assert property (p_mode_fixed)
    else $error("voltage mode changed during a pass");

endmodule // scem_top

// ### testbench/scem_target_model.sv
// Behavioural model of the target logic device at the far end of the serial link.
`timescale 1ns/1ps

module scem_target_model (
  // Shared wire and data pin from the memory.
  input wire logic line,
  input wire logic data,
  input wire logic data_oe,
  // Load-complete timing: 0 at the end, 1 early, 2 never.
  input wire logic [1:0] mode,
  // Link pins driven by the target.
  output logic serial_bit_clock,
  output logic chip_select_n,
  // Received stream and number of bits taken.
  output logic [255:0] rx,
  output logic [9:0] cnt
);
  logic oe_q = 1'h0;
  logic cs_q = 1'h0;
  logic [255:0] rx_q = '0;
  logic [9:0] cnt_q = '0;

  assign chip_select_n = cs_q;
  assign rx = rx_q;
  assign cnt = cnt_q;

  // The clock runs only while loading, so it stands still once load-complete is up.
  initial
  begin
    serial_bit_clock = 1'h0;
    #3.3;
    forever #7.5 serial_bit_clock = ~serial_bit_clock & ~cs_q;
  end

  // A low wire restarts the target; load-complete rides on chip-select.
  always @(negedge serial_bit_clock or negedge line)
  begin
    if (!line)
    begin
      cnt_q <= '0;
      oe_q <= 1'h0;
      cs_q <= 1'h0;
    end
    else
    begin
      oe_q <= data_oe;
      if (data_oe)
      begin
        rx_q <= {data, rx_q[255:1]};
        cnt_q <= cnt_q + 10'h1;
      end
      if ((mode == 2'h0 && oe_q && !data_oe) || (mode == 2'h1 && cnt_q == 10'h64))
        cs_q <= 1'h1;
    end
  end
endmodule // scem_target_model

// ### testbench/test_scem_top.sv
// Self-checking testbench for the serial configuration error monitor.
`timescale 1ns/1ps

module test_scem_top
  import scem_pkg::*;
;
  localparam int POR = 400;
  logic sys_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic fault_n = 1'h0;
  logic [1:0] mode = 2'h0;
  logic prog_bit_we = 1'h0;
  logic prog_bit_data = 1'h0;
  logic prog_opt_we = 1'h0;
  logic prog_opt_auto_restart = 1'h0;
  logic prog_opt_low_voltage = 1'h0;
  scem_addr_t prog_bit_addr = '0;
  scem_store_t store_exp;
  logic opt_lv;
  logic serial_bit_clock, chip_select_n, line_out, line_oe, serial_data_out, serial_data_oe;
  logic low_voltage_mode, config_error, config_done, por_busy;
  logic [255:0] rx;
  logic [9:0] cnt;
  int seed = 32'hc8a43eaf;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  // Open-drain wire: pull-up, the memory's pull-down and the target's own driver.
  wire line = (line_oe ? line_out : 1'h1) & fault_n;

  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= sys_rst ? 0 : cyc + 1;

  scem_top #(.POR_CYCLES(POR)) DUT (
    .sys_clk, .sys_rst, .serial_bit_clock, .chip_select_n, .line_in(line), .line_out,
    .line_oe, .serial_data_out, .serial_data_oe, .prog_bit_we, .prog_bit_addr,
    .prog_bit_data, .prog_opt_we, .prog_opt_auto_restart, .prog_opt_low_voltage,
    .low_voltage_mode, .config_error, .config_done, .por_busy
  );

  scem_target_model tgt (
    .line, .data(serial_data_out), .data_oe(serial_data_oe), .mode, .serial_bit_clock,
    .chip_select_n, .rx, .cnt
  );

  task automatic print_verdict();
    $display("counts: %0d mismatches, %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic clk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] g);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return config_done;
      1: return config_error;
      2: return ~por_busy;
      default: return cnt > 10'h14;
    endcase
  endfunction

  task automatic wait_on(input int k);
    int i;
    for (i = 0; i < 2000 && sig(k) !== 1'h1; i++)
      clk(1);
    if (i == 2000)
    begin
      bad_count++;
      $display("Error wait %0d expected 1 seen timeout", k);
      print_verdict();
    end
  endtask

  // Reset with the target holding the wire low, then program during the power-up delay.
  task automatic reset_prog(input logic a);
    sys_rst = 1'h1;
    fault_n = 1'h0;
    clk(10);
    chk("lv_reset", 0, low_voltage_mode);
    sys_rst = 1'h0;
    fault_n = 1'h1;
    chk("por_busy", 1, por_busy);
    opt_lv = 1'($random(seed));
    prog_opt_auto_restart = a;
    prog_opt_low_voltage = opt_lv;
    prog_opt_we = 1'h1;
    prog_bit_we = 1'h1;
    for (int i = 0; i < 256; i++)
    begin
      prog_bit_addr = scem_addr_t'(i);
      prog_bit_data = (i == 0 || i == 255) ? 1'h1 : 1'($random(seed));
      store_exp[i] = prog_bit_data;
      clk(1);
      prog_opt_we = 1'h0;
    end
    prog_bit_we = 1'h0;
    chk("lv", opt_lv, low_voltage_mode);
    wait_on(2);
    chk("por_len", 1, cyc >= POR - 1 && cyc <= POR + 3);
    chk("por_data", 0, cnt);
    $display("test reset and programming done");
  endtask

  // Target restarts the memory, then writes are tried while the pass runs.
  task automatic pass(input logic [1:0] m, input int k);
    mode = m;
    fault_n = 1'h0;
    clk(8);
    chk("fault", 0, {config_done, line_oe});
    fault_n = 1'h1;
    wait_on(3);
    prog_bit_addr = 8'h05;
    prog_bit_data = ~store_exp[5];
    prog_opt_low_voltage = ~opt_lv;
    prog_bit_we = 1'h1;
    prog_opt_we = 1'h1;
    clk(1);
    prog_bit_we = 1'h0;
    prog_opt_we = 1'h0;
    wait_on(k);
    chk("lv_run", opt_lv, low_voltage_mode);
  endtask

  initial
  begin
    reset_prog(1'h0);
    pass(2'h0, 0);
    chk("rx", store_exp, rx);
    chk("good", 0, {config_error, line_oe});
    $display("test good pass done");
    pass(2'h0, 3);
    pass(2'h0, 0);
    chk("rx_cut", store_exp, rx);
    chk("cut", 0, {config_error, line_oe});
    $display("test cut pass done");
    pass(2'h1, 1);
    clk(60);
    chk("early", 3'h6, {config_error, line_oe, line});
    chk("early_done", 0, config_done);
    $display("test early load-complete done");
    reset_prog(1'h1);
    pass(2'h2, 1);
    chk("late", 2'h3, {config_error, line_oe});
    mode = 2'h0;
    clk(12);
    chk("release", 0, line_oe);
    wait_on(0);
    chk("restart", 0, config_error);
    chk("rx_restart", store_exp, rx);
    $display("test auto-restart done");
    print_verdict();
  end
endmodule // test_scem_top
